// file: bench/ptm_pin_model.sv
// ptm_pin_model: far-side driver of the two external count / gate pins
// assumes: bench calls pulses() from its main thread, one pin at a time
`timescale 1ns/1ps
module ptm_pin_model (
  // clock
  input  wire logic hclk,
  // pins, held low outside bursts
  output logic      lower_pin,
  output logic      upper_pin
);
  // both pins start low
  initial begin
    lower_pin = 1'b0;
    upper_pin = 1'b0;
  end

  // drive one of the two pins
  task automatic set_pin(input bit up, input logic val);
    if (up)
      upper_pin <= val;
    else
      lower_pin <= val;
  endtask : set_pin

  // n pulses, each level held w clocks so the synchroniser can see it
  task automatic pulses(input bit up, input int n, input int w);
    repeat (n) begin
      @(posedge hclk);
      set_pin(up, 1'b1);
      repeat (w) @(posedge hclk);
      set_pin(up, 1'b0);
      repeat (w - 1) @(posedge hclk);
    end
  endtask : pulses
endmodule : ptm_pin_model

// file: bench/test_paired_timer_16_32bit.sv
// test_paired_timer_16_32bit: self-checking bench for both timer pairs
// assumes: ptm_pkg and the pin model are compiled first
`timescale 1ns/1ps
module test_paired_timer_16_32bit;
  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic        hclk, hresetn, tgt, hwrite, idle_mode, hready, irq_t;
  logic        rdy_a, rdy_b, irq_a, irq_b, adc_a, adc_b, pin_lo, pin_hi;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rd_a, rd_b;
  int          errors, n_tests, adc_cnt_a, adc_cnt_b;

  // one slave selected at a time
  assign hready = tgt ? rdy_b : rdy_a;
  assign irq_t  = tgt ? irq_b : irq_a;

  ptm_timer_pair #(.FIRST_PAIR(1'b1)) DUT (
    .hclk, .hresetn, .hsel(~tgt), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout(rdy_a), .hresp(), .hrdata(rd_a), .idle_mode,
    .external_count_clock_pin(pin_lo), .upper_external_count_clock_pin(pin_hi),
    .irq(irq_a), .adc_trigger(adc_a));
  ptm_timer_pair #(.FIRST_PAIR(1'b0)) DUT2 (
    .hclk, .hresetn, .hsel(tgt), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout(rdy_b), .hresp(), .hrdata(rd_b), .idle_mode,
    .external_count_clock_pin(pin_lo), .upper_external_count_clock_pin(pin_hi),
    .irq(irq_b), .adc_trigger(adc_b));
  ptm_pin_model pins (.hclk, .lower_pin(pin_lo), .upper_pin(pin_hi));

  // clock and adc pulse counters
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    if (adc_a === 1'b1) adc_cnt_a++;
    if (adc_b === 1'b1) adc_cnt_b++;
  end

  // ---------------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------------
  task automatic bus(input bit w, input logic [7:0] off, input logic [31:0] wd,
                     output logic [31:0] rv);
    @(posedge hclk);
    haddr  <= 32'(off);
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rv = tgt ? rd_b : rd_a;
  endtask : bus
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    logic [31:0] nul;
    bus(1'b1, off, d, nul);
  endtask : wr
  task automatic rd(input logic [7:0] off, output logic [31:0] v);
    bus(1'b0, off, 32'h0000_0000, v);
  endtask : rd
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // counts whose start phase is uncertain by one tick
  task automatic near(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if ($isunknown(got) || got + 1 < exp || got > exp + 1) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : near
  task automatic expect_reg(input logic [7:0] off, input logic [31:0] exp);
    logic [31:0] v;
    rd(off, v);
    check(v, exp);
  endtask : expect_reg
  task automatic wait_irq(input int lim);
    for (int k = 0; k < lim && irq_t !== 1'b1; k++) @(posedge hclk);
  endtask : wait_irq
  function automatic int div_shift(input int code);
    return (code == 0) ? 0 : (code == 3) ? 8 : 3 * code;
  endfunction : div_shift
  task automatic end_sim();
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // 32-bit run across the word carry to a 32-bit period match
  task automatic join_run();
    logic [31:0] v;
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_0000);
    wr(ptm_pkg::OFF_LO_CNT, 32'h0000_FFF0);
    wr(ptm_pkg::OFF_HI_CNT, 32'h0000_0000);
    wr(ptm_pkg::OFF_LO_PER, 32'h0000_0008);
    wr(ptm_pkg::OFF_HI_PER, 32'h0000_0001);
    wr(ptm_pkg::OFF_MASK, 32'h0000_0003);
    rd(ptm_pkg::OFF_STATUS, v);
    wr(ptm_pkg::OFF_HI_CTL, 32'h0000_8030);  // slow upper setting, must be ignored
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_8008);
    repeat (18) @(posedge hclk);
    expect_reg(ptm_pkg::OFF_HI_CNT, 32'h0000_0001);
    wait_irq(40);
    check({31'h0, irq_t}, 32'h0000_0001);
    expect_reg(ptm_pkg::OFF_STATUS, 32'h0000_0002);
    expect_reg(ptm_pkg::OFF_HI_CNT, 32'h0000_0000);
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_0000);
  endtask : join_run

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    logic [31:0] v, w;
    int          p;
    hclk = 1'b0;
    hresetn = 1'b0;
    tgt = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    idle_mode = 1'b0;
    void'($urandom(32'h6b651edd));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and reserved bits
    expect_reg(ptm_pkg::OFF_LO_CTL, 32'h0000_0000);
    expect_reg(ptm_pkg::OFF_HI_PER, 32'h0000_FFFF);
    expect_reg(ptm_pkg::OFF_MASK, 32'h0000_0000);
    expect_reg(ptm_pkg::OFF_STATUS, 32'h0000_0000);
    expect_reg(8'h40, 32'h0000_0000);  // unmapped place reads zero
    repeat (4) begin
      v = $urandom & 32'hFFFF_7FFF;
      wr(ptm_pkg::OFF_LO_CTL, v);
      expect_reg(ptm_pkg::OFF_LO_CTL, {16'h0000, v[15:0] & 16'hA07A});
      wr(ptm_pkg::OFF_HI_CTL, v);
      expect_reg(ptm_pkg::OFF_HI_CTL, {16'h0000, v[15:0] & 16'hA072});
    end
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_0000);
    wr(ptm_pkg::OFF_HI_CTL, 32'h0000_0000);
    // every prescale code on the internal clock, then stop holds the count
    for (int c = 0; c < 4; c++) begin
      wr(ptm_pkg::OFF_LO_CNT, 32'h0000_0000);
      wr(ptm_pkg::OFF_LO_CTL, 32'h0000_8000 | 32'(c << 4));
      repeat (1021) @(posedge hclk);
      wr(ptm_pkg::OFF_LO_CTL, 32'(c << 4));
      rd(ptm_pkg::OFF_LO_CNT, v);
      near(v, 32'(1024 >> div_shift(c)));
      rd(ptm_pkg::OFF_LO_CNT, w);
      check(w, v);
    end
    // idle halt set, then clear, with the device idle
    idle_mode <= 1'b1;
    wr(ptm_pkg::OFF_LO_CNT, 32'h0000_0000);
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_A000);
    repeat (97) @(posedge hclk);
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_0000);
    expect_reg(ptm_pkg::OFF_LO_CNT, 32'h0000_0000);
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_8000);
    repeat (97) @(posedge hclk);
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_0000);
    rd(ptm_pkg::OFF_LO_CNT, v);
    near(v, 32'd100);
    idle_mode <= 1'b0;
    // rewrites while running keep a 1:256 prescaler from ever finishing
    wr(ptm_pkg::OFF_LO_CNT, 32'h0000_0000);
    repeat (6) begin
      wr(ptm_pkg::OFF_LO_CTL, 32'h0000_8030);
      repeat (150) @(posedge hclk);
    end
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_0030);
    expect_reg(ptm_pkg::OFF_LO_CNT, 32'h0000_0000);
    // 16-bit lower match with random period, masked then unmasked
    p = 40 + ($urandom % 16);
    wr(ptm_pkg::OFF_LO_CNT, 32'h0000_0000);
    wr(ptm_pkg::OFF_LO_PER, 32'(p));
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_8000);
    repeat (p + 8) @(posedge hclk);
    check({31'h0, irq_a}, 32'h0000_0000);  // masked event keeps irq low
    expect_reg(ptm_pkg::OFF_STATUS, 32'h0000_0001);
    expect_reg(ptm_pkg::OFF_STATUS, 32'h0000_0000);  // read clears
    wr(ptm_pkg::OFF_MASK, 32'h0000_0001);
    wait_irq(p + 8);
    check({31'h0, irq_a}, 32'h0000_0001);
    rd(ptm_pkg::OFF_STATUS, v);
    repeat (2) @(posedge hclk);
    check({31'h0, irq_a}, 32'h0000_0000);
    check(32'(adc_cnt_a), 32'h0000_0000);
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_0000);
    wr(ptm_pkg::OFF_LO_PER, 32'h0000_FFFF);
    // external pin edges: lower 1:8 and upper 1:1, both with gate ignored
    for (int u = 0; u < 2; u++) begin
      wr(u ? ptm_pkg::OFF_HI_CNT : ptm_pkg::OFF_LO_CNT, 32'h0000_0000);
      wr(u ? ptm_pkg::OFF_HI_CTL : ptm_pkg::OFF_LO_CTL, u ? 32'h0000_8042 : 32'h0000_8052);
      pins.pulses(u[0], u ? 5 : 16, 3);
      repeat (6) @(posedge hclk);
      expect_reg(u ? ptm_pkg::OFF_HI_CNT : ptm_pkg::OFF_LO_CNT, u ? 32'd5 : 32'd2);
      wr(u ? ptm_pkg::OFF_HI_CTL : ptm_pkg::OFF_LO_CTL, 32'h0000_0000);
    end
    // gated accumulation on the internal clock
    wr(ptm_pkg::OFF_LO_CNT, 32'h0000_0000);
    rd(ptm_pkg::OFF_STATUS, v);
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_8040);
    pins.pulses(1'b0, 1, 40);
    repeat (6) @(posedge hclk);
    rd(ptm_pkg::OFF_LO_CNT, v);
    near(v, 32'd40);
    expect_reg(ptm_pkg::OFF_STATUS, 32'h0000_0001);
    wr(ptm_pkg::OFF_LO_CTL, 32'h0000_0000);
    // joined mode on the first pair, then on the second
    for (int t = 0; t < 2; t++) begin
      tgt <= t[0];
      join_run();
    end
    check(32'(adc_cnt_a), 32'h0000_0001);
    check(32'(adc_cnt_b), 32'h0000_0000);
    end_sim();
  end

  // watchdog
  initial begin
    repeat (30000) @(posedge hclk);
    errors++;
    end_sim();
  end
endmodule : test_paired_timer_16_32bit

// file: hw/ptm_prescale.sv
// ptm_prescale: input clock prescaler for one 16-bit timer
// assumes: tick_in is a one-cycle qualifier on hclk; clear is a same-clock pulse
`timescale 1ns/1ps
module ptm_prescale (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic [1:0] sel,
  input  wire logic       clear,
  // ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [7:0] cnt_q;
  logic [7:0] lim;

  // ------------------------------------------------------------------
  // terminal count per ratio
  // ------------------------------------------------------------------
  always_comb begin
    case (sel)
      2'b00:   lim = ptm_pkg::PS_LIM_1;
      2'b01:   lim = ptm_pkg::PS_LIM_8;
      2'b10:   lim = ptm_pkg::PS_LIM_64;
      default: lim = ptm_pkg::PS_LIM_256;
    endcase
  end

  // one output tick per lim+1 input ticks  [R04]
  assign tick_out = tick_in && !clear && (cnt_q >= lim);

  // ------------------------------------------------------------------
  // prescale counter, cleared by a control write
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 8'h00;
    end else if (clear) begin  // [R08]
      cnt_q <= 8'h00;
    end else if (tick_in) begin
      cnt_q <= (cnt_q >= lim) ? 8'h00 : cnt_q + 8'h01;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_div_range: assert property (  // [R04]
    (sel == 2'b01 && $stable(sel)) |=> (cnt_q <= 8'h07))
    else $error("prescale count exceeds divide-by-8 range");

endmodule : ptm_prescale

// file: hw/ptm_timer_pair.sv
// ptm_timer_pair: two 16-bit timers that may join into one 32-bit timer
// assumes: ahb-lite single master, hclk is the internal instruction clock,
// idle_mode comes from logic on hclk, the count pins are asynchronous
//
// Notes on behaviour
// [R01] lower run bit starts/stops lower timer, or the joined 32-bit timer
// [R02] idle-halt bit set stops the timer while the device idles
// [R03] gating bit ignored with external clock; otherwise enables gated counting
// [R04] prescale codes 00/01/10/11 divide input clock by 1/8/64/256
// [R05] join bit set makes lower and upper timers one 32-bit timer
// [R06] in 32-bit mode upper control register has no effect
// [R07] clock source bit picks pin rising edge, else internal clock
// [R08] control write while running resets that timer's prescaler
// [R09] only upper timer of the first pair drives the adc trigger
// [R10] second pair's join bit sits at same position, same behaviour
// [R11] unimplemented control bits read as zero
// [R12] in 32-bit mode upper word holds msw, lower word lsw
// [R13] 32-bit timer uses lower clock and gate, flags upper interrupt
// [R14] 32-bit count matching 32-bit period raises the interrupt
// [R15] period match returns count to zero and sets the flag
// [R16] gated counting runs while gate high; flag on gate falling edge
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module ptm_timer_pair #(
  parameter bit FIRST_PAIR = 1'b1
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // device state and pins
  input  wire logic        idle_mode,
  input  wire logic        external_count_clock_pin,
  input  wire logic        upper_external_count_clock_pin,
  // events
  output logic             irq,
  output logic             adc_trigger
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [15:0] lower_ctl_q, upper_ctl_q;
  logic [15:0] lower_count_word_q, upper_count_word_q;
  logic [15:0] lower_per_q, upper_per_q;
  logic [1:0]  sts_q, sts_d, msk_q, msk_d;
  logic [7:0]  addr_q;
  logic        wr_q, rd_lo_ctl_q, rd_hi_ctl_q;
  logic [31:0] hrdata_q;
  logic        irq_q, adc_q;
  logic [1:0]  pin_s1_q, pin_s2_q, pin_s3_q;

  logic        pair32;
  logic        addr_ph, rd_ph;
  logic [31:0] rd_word;
  logic        wr_lo_ctl, wr_hi_ctl, wr_lo_cnt, wr_hi_cnt;
  logic [15:0] ctl   [2];
  logic [1:0]  run, gated, rise, fall, src, clr, tick, gate_evt;
  logic        match_lo, match_hi, match_32, mat0, mat1;
  logic [1:0]  evt;

  assign pair32 = lower_ctl_q[ptm_pkg::BIT_JOIN];  // [R05] [R10]
  assign ctl[0] = lower_ctl_q;
  assign ctl[1] = upper_ctl_q;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  assign addr_ph   = hsel && hready && htrans[1];
  assign rd_ph     = addr_ph && !hwrite;
  assign wr_lo_ctl = wr_q && addr_q == ptm_pkg::OFF_LO_CTL;
  assign wr_hi_ctl = wr_q && addr_q == ptm_pkg::OFF_HI_CTL;
  assign wr_lo_cnt = wr_q && addr_q == ptm_pkg::OFF_LO_CNT;
  assign wr_hi_cnt = wr_q && addr_q == ptm_pkg::OFF_HI_CNT;

  // read data, picked in the address phase so it leaves a flop
  always_comb begin
    case (haddr[7:0])
      ptm_pkg::OFF_LO_CTL: rd_word = {16'h0000, lower_ctl_q & ptm_pkg::LO_CTL_MASK}; // [R11]
      ptm_pkg::OFF_HI_CTL: rd_word = {16'h0000, upper_ctl_q & ptm_pkg::HI_CTL_MASK}; // [R11]
      ptm_pkg::OFF_LO_CNT: rd_word = {16'h0000, lower_count_word_q};
      ptm_pkg::OFF_HI_CNT: rd_word = {16'h0000, upper_count_word_q};
      ptm_pkg::OFF_LO_PER: rd_word = {16'h0000, lower_per_q};
      ptm_pkg::OFF_HI_PER: rd_word = {16'h0000, upper_per_q};
      ptm_pkg::OFF_STATUS: rd_word = {30'h0000_0000, sts_q};
      ptm_pkg::OFF_MASK:   rd_word = {30'h0000_0000, msk_q};
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  // address phase capture and read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q      <= 8'h00;
      wr_q        <= 1'b0;
      rd_lo_ctl_q <= 1'b0;
      rd_hi_ctl_q <= 1'b0;
      hrdata_q    <= 32'h0000_0000;
    end else begin
      addr_q      <= haddr[7:0];
      wr_q        <= addr_ph && hwrite;
      rd_lo_ctl_q <= rd_ph && haddr[7:0] == ptm_pkg::OFF_LO_CTL;
      rd_hi_ctl_q <= rd_ph && haddr[7:0] == ptm_pkg::OFF_HI_CTL;
      if (rd_ph) begin
        hrdata_q <= rd_word;
      end
    end
  end

  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay
  assign hrdata    = hrdata_q;

  // ------------------------------------------------------------------
  // control, period and mask registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lower_ctl_q <= ptm_pkg::CTL_RESET;
      upper_ctl_q <= ptm_pkg::CTL_RESET;
      lower_per_q <= ptm_pkg::PER_RESET;
      upper_per_q <= ptm_pkg::PER_RESET;
      msk_q       <= ptm_pkg::STS_RESET;
    end else if (wr_q) begin
      case (addr_q)
        ptm_pkg::OFF_LO_CTL: lower_ctl_q <= hwdata[15:0] & ptm_pkg::LO_CTL_MASK; // [R11]
        ptm_pkg::OFF_HI_CTL: upper_ctl_q <= hwdata[15:0] & ptm_pkg::HI_CTL_MASK; // [R11]
        ptm_pkg::OFF_LO_PER: lower_per_q <= hwdata[15:0];
        ptm_pkg::OFF_HI_PER: upper_per_q <= hwdata[15:0];
        ptm_pkg::OFF_MASK:   msk_q       <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // pin synchronisers: s1 feeds s2 only, s3 is the edge history
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 2'b00;
      pin_s2_q <= 2'b00;
      pin_s3_q <= 2'b00;
    end else begin
      pin_s1_q <= {upper_external_count_clock_pin, external_count_clock_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ------------------------------------------------------------------
  // per-timer clocking: source, gate, idle, prescale
  // ------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    logic joined_off;
    assign joined_off = (i == 1) && pair32;  // upper control ignored when joined [R06]
    assign rise[i]  = pin_s2_q[i] && !pin_s3_q[i];
    assign fall[i]  = !pin_s2_q[i] && pin_s3_q[i];
    assign gated[i] = !ctl[i][ptm_pkg::BIT_CSRC] && ctl[i][ptm_pkg::BIT_GATE];  // [R03]
    // run bit, halted in idle when asked  [R01] [R02]
    assign run[i] = ctl[i][ptm_pkg::BIT_RUN] && !joined_off
                    && !(ctl[i][ptm_pkg::BIT_IDLE] && idle_mode);
    // pin rising edge, gate level, or internal clock  [R07] [R16]
    assign src[i] = ctl[i][ptm_pkg::BIT_CSRC] ? rise[i] : (gated[i] ? pin_s2_q[i] : 1'b1);
    assign gate_evt[i] = run[i] && gated[i] && fall[i];  // [R16]
    // every control write clears, so no stale count outlives a ratio change
    assign clr[i] = (i == 0) ? wr_lo_ctl : wr_hi_ctl;  // [R08]
    ptm_prescale u_ps (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .sel      (ctl[i][ptm_pkg::BIT_PS_HI:ptm_pkg::BIT_PS_LO]),
      .clear    (clr[i]),
      .tick_in  (run[i] && src[i]),
      .tick_out (tick[i])
    );
  end

  // ------------------------------------------------------------------
  // period compare
  // ------------------------------------------------------------------
  assign match_lo = lower_count_word_q == lower_per_q;
  assign match_hi = upper_count_word_q == upper_per_q;
  assign match_32 = match_lo && match_hi;  // [R14]
  assign mat0     = !pair32 && tick[0] && match_lo;  // [R15]
  assign mat1     = pair32 ? (tick[0] && match_32) : (tick[1] && match_hi);  // [R13] [R15]
  assign evt[0]   = mat0 || (!pair32 && gate_evt[0]);
  assign evt[1]   = mat1 || (pair32 ? gate_evt[0] : gate_evt[1]);  // [R13]

  // ------------------------------------------------------------------
  // lower count word: lsw in 32-bit mode
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lower_count_word_q <= ptm_pkg::CNT_RESET;
    end else if (wr_lo_cnt) begin
      lower_count_word_q <= hwdata[15:0];
    end else if (tick[0]) begin
      if (pair32 ? match_32 : match_lo) begin  // [R14] [R15]
        lower_count_word_q <= ptm_pkg::CNT_RESET;
      end else begin
        lower_count_word_q <= lower_count_word_q + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // upper count word: msw in 32-bit mode, carried from lower
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upper_count_word_q <= ptm_pkg::CNT_RESET;
    end else if (wr_hi_cnt) begin
      upper_count_word_q <= hwdata[15:0];
    end else if (pair32) begin
      if (tick[0] && match_32) begin  // [R14]
        upper_count_word_q <= ptm_pkg::CNT_RESET;
      end else if (tick[0] && lower_count_word_q == 16'hFFFF) begin  // [R12]
        upper_count_word_q <= upper_count_word_q + 16'h0001;
      end
    end else if (tick[1]) begin
      if (match_hi) begin  // [R15]
        upper_count_word_q <= ptm_pkg::CNT_RESET;
      end else begin
        upper_count_word_q <= upper_count_word_q + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // sticky status, read clears, a new event wins over the clear
  // ------------------------------------------------------------------
  always_comb begin
    sts_d = sts_q;
    if (rd_ph && haddr[7:0] == ptm_pkg::OFF_STATUS) begin
      sts_d = 2'b00;
    end
    sts_d = sts_d | evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_q <= ptm_pkg::STS_RESET;
    end else begin
      sts_q <= sts_d;
    end
  end

  // mask after this edge, so irq follows a mask write without a lag
  assign msk_d = (wr_q && addr_q == ptm_pkg::OFF_MASK) ? hwdata[1:0] : msk_q;

  // interrupt level and adc trigger pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
      adc_q <= 1'b0;
    end else begin
      irq_q <= |(sts_d & msk_d);
      adc_q <= FIRST_PAIR && mat1;  // [R09]
    end
  end

  assign irq         = irq_q;
  assign adc_trigger = adc_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_rsvd_read_zero: assert property (  // [R11]
    rd_lo_ctl_q |-> (hrdata_q[15:0] & ~ptm_pkg::LO_CTL_MASK) == 16'h0000
                    && hrdata_q[31:16] == 16'h0000)
    else $error("reserved lower control bits read nonzero");

  a_stop_hold: assert property (  // [R01]
    (!lower_ctl_q[ptm_pkg::BIT_RUN] && !wr_lo_cnt) |=> $stable(lower_count_word_q))
    else $error("lower count moved while stopped");

  a_idle_halt: assert property (  // [R02]
    (idle_mode && lower_ctl_q[ptm_pkg::BIT_IDLE] && !wr_lo_cnt)
      |=> $stable(lower_count_word_q))
    else $error("lower count moved in idle with halt selected");

  a_ext_gate_ign: assert property (  // [R03]
    (lower_ctl_q[ptm_pkg::BIT_CSRC] && !rise[0] && !wr_lo_cnt)
      |=> $stable(lower_count_word_q))
    else $error("external source counted without pin edge");

  a_int_count: assert property (  // [R07]
    (run[0] && !pair32 && !gated[0] && !lower_ctl_q[ptm_pkg::BIT_CSRC]
     && lower_ctl_q[ptm_pkg::BIT_PS_HI:ptm_pkg::BIT_PS_LO] == 2'b00
     && !match_lo && !wr_lo_cnt && !wr_lo_ctl)
      |=> lower_count_word_q == $past(lower_count_word_q) + 16'h0001)
    else $error("internal clock at 1:1 did not advance count");

  a_join_ignore: assert property (  // [R06]
    (pair32 && !tick[0] && !wr_hi_cnt && !wr_lo_ctl) |=> $stable(upper_count_word_q))
    else $error("upper word moved in 32-bit mode without lower tick");

  a_carry_up: assert property (  // [R05] [R12]
    (pair32 && tick[0] && lower_count_word_q == 16'hFFFF && !match_32 && !wr_hi_cnt
     && !wr_lo_cnt)
      |=> upper_count_word_q == $past(upper_count_word_q) + 16'h0001
          && lower_count_word_q == 16'h0000)
    else $error("32-bit carry into upper word missing");

  a_match_wrap: assert property (  // [R15]
    (!pair32 && tick[0] && match_lo && !wr_lo_cnt)
      |=> lower_count_word_q == 16'h0000 && sts_q[ptm_pkg::STS_LO])
    else $error("16-bit period match did not wrap and flag");

  a_join_flag: assert property (  // [R13] [R14]
    (pair32 && tick[0] && match_32) |=> sts_q[ptm_pkg::STS_HI] ##1 1'b1)
    else $error("32-bit match did not set upper flag");

  a_gate_fall: assert property (  // [R16]
    (gate_evt[0] && !pair32) |=> sts_q[ptm_pkg::STS_LO])
    else $error("gate falling edge did not set lower flag");

  a_pre_clear: assert property (  // [R08]
    (wr_lo_ctl && run[0]) |=> g_tmr[0].u_ps.cnt_q == 8'h00)
    else $error("control write while running kept prescale count");

  a_adc_only: assert property (  // [R09]
    adc_q |-> FIRST_PAIR && $past(mat1))
    else $error("adc trigger without upper match on first pair");

  a_irq_level: assert property (
    irq_q == |(sts_q & msk_q))
    else $error("unmasked status without interrupt");

endmodule : ptm_timer_pair

// file: shared/ptm_pkg.sv
// ptm_pkg: register map, field positions and reset values of the paired timer
// assumes: one aligned 32-bit word per register on an ahb-lite slave
package ptm_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_LO_CTL = 8'h00;  // lower_timer_control
  localparam logic [7:0] OFF_HI_CTL = 8'h04;  // upper_timer_control
  localparam logic [7:0] OFF_LO_CNT = 8'h08;  // lower_count_word
  localparam logic [7:0] OFF_HI_CNT = 8'h0C;  // upper_count_word
  localparam logic [7:0] OFF_LO_PER = 8'h10;  // lower period word
  localparam logic [7:0] OFF_HI_PER = 8'h14;  // upper period word
  localparam logic [7:0] OFF_STATUS = 8'h18;  // sticky event flags, read clears
  localparam logic [7:0] OFF_MASK   = 8'h1C;  // interrupt mask, same layout

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int BIT_RUN   = 15;  // run_enable
  localparam int BIT_IDLE  = 13;  // idle_halt_select
  localparam int BIT_GATE  = 6;   // gated_accumulate_enable
  localparam int BIT_PS_HI = 5;   // prescale_select msb
  localparam int BIT_PS_LO = 4;   // prescale_select lsb
  localparam int BIT_JOIN  = 3;   // pair_join_select / second_pair_join_select
  localparam int BIT_CSRC  = 1;   // clock_source_select

  // implemented bits; all others read zero
  localparam logic [15:0] LO_CTL_MASK = 16'hA07A;
  localparam logic [15:0] HI_CTL_MASK = 16'hA072;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] PER_RESET = 16'hFFFF;
  localparam logic [1:0]  STS_RESET = 2'h0;

  // status / mask bits
  localparam int STS_LO = 0;
  localparam int STS_HI = 1;

  // ----------------------------------------------------------------------
  // prescale terminal counts: divide by 1, 8, 64, 256
  // ----------------------------------------------------------------------
  localparam logic [7:0] PS_LIM_1   = 8'h00;
  localparam logic [7:0] PS_LIM_8   = 8'h07;
  localparam logic [7:0] PS_LIM_64  = 8'h3F;
  localparam logic [7:0] PS_LIM_256 = 8'hFF;

endpackage : ptm_pkg
